/* File: rtl/lpdh_defs.vh */
// constants for the low-power debug handshake block
// assumes one free-running always-on clock; the system clock is gated downstream
`ifndef LPDH_DEFS_VH
`define LPDH_DEFS_VH

`define LPDH_CFG_W         32
`define LPDH_CFG_RESET     32'h0000_0000
`define LPDH_CFG_WMASK     32'h0000_010f
`define LPDH_BIT_LPDE      0
`define LPDH_BIT_CKOE      1
`define LPDH_DIV_LO        2
`define LPDH_DIV_HI        3
`define LPDH_BIT_FLAG      8

`define LPDH_DIV1          2'h0
`define LPDH_DIV2          2'h1
`define LPDH_DIV4          2'h2
`define LPDH_DIV8          2'h3

`define LPDH_MODE_W        4
`define LPDH_MODE_HALT     4'h8
`define LPDH_MODE_STOP     4'ha
`define LPDH_MODE_STANDBY  4'hd

`define LPDH_AON_W         16
`define LPDH_AON_RESET     16'h0001
`define LPDH_AON_BIT_OSC   0

`define LPDH_CLK_MHZ       40
`define LPDH_WAKE_US       42
`define LPDH_WAKE_CYC      (`LPDH_WAKE_US * `LPDH_CLK_MHZ)
`define LPDH_CNT_W         11
// load value of the wake counter: LPDH_WAKE_CYC minus one, sized to the counter
`define LPDH_WAKE_LOAD     11'h68f

`endif

/* File: rtl/lpdh_clkdiv.v */
// debug clock output generator: gate plus divide by 1, 2, 4 or 8
// assumes clk_i is the always-on clock; run_i low while the system clock is stopped
`timescale 1ns/1ps
`include "lpdh_defs.vh"
module lpdh_clkdiv (
  input  wire       clk_i,
  input  wire       rst_b_i,
  input  wire       en_i,
  input  wire [1:0] div_i,
  input  wire       run_i,
  output wire       debug_clock_output_o
);
  reg  [2:0] cnt_q;
  reg        div_clk_q;
  reg        on_q;
  reg  [2:0] half;

  always @* begin
    case (div_i)
      `LPDH_DIV2: half = 3'h0;
      `LPDH_DIV4: half = 3'h1;
      default:    half = 3'h3;
    endcase
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q     <= 3'h0;
      div_clk_q <= 1'b0;
    end else begin
      if (!(en_i & run_i)) begin
        cnt_q     <= 3'h0;
        div_clk_q <= 1'b0;
      end else if (cnt_q >= half) begin // divider change may leave count above new half
        cnt_q     <= 3'h0;
        div_clk_q <= ~div_clk_q;
      end else begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

  // gate moves only while clk_i is low, so the divide-by-one path never glitches
  always @(negedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      on_q <= 1'b0;
    end else begin
      on_q <= en_i & run_i;
    end
  end

  // divide by one has to pass the clock itself through the gate above
  assign debug_clock_output_o = (div_i == `LPDH_DIV1) ? (clk_i & on_q)
                                                      : div_clk_q;
endmodule // lpdh_clkdiv

/* File: rtl/lpdh_top.v */
// low-power entry/exit sequencer with debugger handshake and debug config register
// assumes clk_i is an always-on clock; the gated system clock is system_clock_en_o
`timescale 1ns/1ps
`include "lpdh_defs.vh"
module lpdh_top (
  input  wire                    clk_i,
  input  wire                    rst_b_i,
  // software write of the mode control register
  input  wire                    mode_wr_i,
  input  wire [`LPDH_MODE_W-1:0] mode_target_i,
  // always-on domain register write from software
  input  wire                    aon_wr_i,
  input  wire [`LPDH_AON_W-1:0]  aon_wdata_i,
  // debugger access port, the only path to the config register
  input  wire                    dbg_wr_i,
  input  wire [`LPDH_CFG_W-1:0]  dbg_wdata_i,
  output reg  [`LPDH_CFG_W-1:0]  dbg_rdata_o,
  // wake-up sources
  input  wire                    wake_timer_i,
  input  wire                    wake_pin_i,
  // jtag data out from the test logic, and the pad
  input  wire                    jtag_tdo_i,
  input  wire                    jtag_tdo_oe_i,
  output wire                    tdo_o,
  output wire                    tdo_oe_o,
  // system side
  output wire                    system_clock_en_o,
  output wire                    mode_busy_o,
  output reg                     sw_resume_o,
  output wire                    code_flash_wake_o,
  output wire                    data_flash_wake_o,
  output wire                    slow_osc_run_o,
  output wire                    debug_pwr_on_o,
  output reg  [`LPDH_AON_W-1:0]  aon_q,
  output reg  [`LPDH_MODE_W-1:0] mode_q,
  output wire                    debug_clock_output_o
);
  localparam [5:0] ST_RUN  = 6'h01;
  localparam [5:0] ST_ENTS = 6'h02;
  localparam [5:0] ST_LOWP = 6'h04;
  localparam [5:0] ST_WAKE = 6'h08;
  localparam [5:0] ST_EXS  = 6'h10;
  localparam [5:0] ST_DONE = 6'h20;

  reg [5:0]             st_q;
  reg [5:0]             st_d;
  reg [`LPDH_CFG_W-1:0] cfg_q;
  reg [`LPDH_CFG_W-1:0] cfg_d;
  reg [`LPDH_CNT_W-1:0] cnt_q;
  reg                   hs_q;
  reg                   hold_q;
  reg                   hold_val_q;
  reg                   set_flag;
  reg                   clr_flag;
  wire                  standby;
  wire                  gated;
  wire                  wake;

  function is_lowpower;
    input [`LPDH_MODE_W-1:0] m;
    begin
      is_lowpower = (m == `LPDH_MODE_HALT) || (m == `LPDH_MODE_STOP) ||
                    (m == `LPDH_MODE_STANDBY);
    end
  endfunction

  assign standby = (mode_q == `LPDH_MODE_STANDBY);
  // debug logic is power-gated only while actually sitting in standby
  assign gated   = standby & ((st_q == ST_LOWP) | (st_q == ST_WAKE));
  assign wake    = wake_timer_i | wake_pin_i;

  always @* begin
    st_d     = st_q;
    set_flag = 1'b0;
    clr_flag = 1'b0;
    case (st_q)
      ST_RUN: begin
        if (mode_wr_i && is_lowpower(mode_target_i)) begin
          if (cfg_q[`LPDH_BIT_LPDE]) begin
            set_flag = 1'b1;
            st_d     = ST_ENTS;
          end else begin
            st_d = ST_LOWP;
          end
        end
      end
      ST_ENTS: begin
        // no timeout: a silent debugger keeps the part awake
        if (!cfg_q[`LPDH_BIT_FLAG]) begin
          st_d = ST_LOWP;
        end
      end
      ST_LOWP: begin
        if (wake) begin
          st_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (cnt_q == {`LPDH_CNT_W{1'b0}}) begin
          st_d = hs_q ? ST_EXS : ST_DONE;
        end
      end
      ST_EXS: begin
        if (cfg_q[`LPDH_BIT_FLAG]) begin
          st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        clr_flag = 1'b1;
        st_d     = ST_RUN;
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
  end

  // config register: debugger write, then device clear unless that write sets the flag, then device set
  always @* begin
    cfg_d = cfg_q;
    if (dbg_wr_i && !gated) begin
      cfg_d = dbg_wdata_i & `LPDH_CFG_WMASK;
    end
    if (clr_flag && !(dbg_wr_i && dbg_wdata_i[`LPDH_BIT_FLAG])) begin
      cfg_d[`LPDH_BIT_FLAG] = 1'b0;
    end
    if (set_flag) begin
      cfg_d[`LPDH_BIT_FLAG] = 1'b1;
    end
    if (gated) begin
      cfg_d = `LPDH_CFG_RESET;
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q        <= ST_RUN;
      cfg_q       <= `LPDH_CFG_RESET;
      cnt_q       <= {`LPDH_CNT_W{1'b0}};
      hs_q        <= 1'b0;
      hold_q      <= 1'b0;
      hold_val_q  <= 1'b1;
      mode_q      <= {`LPDH_MODE_W{1'b0}};
      sw_resume_o <= 1'b0;
      dbg_rdata_o <= `LPDH_CFG_RESET;
    end else begin
      st_q        <= st_d;
      cfg_q       <= cfg_d;
      dbg_rdata_o <= cfg_d;
      sw_resume_o <= (st_q == ST_DONE);
      if (st_q == ST_RUN && st_d != ST_RUN) begin
        mode_q <= mode_target_i;
        // after standby the debug register is gone, so no exit handshake
        hs_q   <= cfg_q[`LPDH_BIT_LPDE] &&
                  (mode_target_i != `LPDH_MODE_STANDBY);
      end
      if (st_q == ST_LOWP && wake) begin
        cnt_q <= `LPDH_WAKE_LOAD;
      end else if (cnt_q != {`LPDH_CNT_W{1'b0}}) begin
        cnt_q <= cnt_q - {{(`LPDH_CNT_W-1){1'b0}}, 1'b1};
      end
      if (st_d == ST_LOWP && hs_q_next(st_q, cfg_q, mode_target_i, hs_q)) begin
        hold_q     <= 1'b1;
        hold_val_q <= 1'b1;
      end else if (st_q == ST_LOWP && st_d == ST_WAKE && hold_q) begin
        hold_val_q <= 1'b0;
      end else if (st_q == ST_DONE) begin
        hold_q     <= 1'b0;
        hold_val_q <= 1'b1;
      end
    end
  end

  // handshake in force for the low-power period being entered
  function hs_q_next;
    input [5:0]             s;
    input [`LPDH_CFG_W-1:0] c;
    input [`LPDH_MODE_W-1:0] m;
    input                   h;
    begin
      if (s == ST_RUN) begin
        hs_q_next = c[`LPDH_BIT_LPDE] && (m != `LPDH_MODE_STANDBY);
      end else begin
        hs_q_next = h;
      end
    end
  endfunction

  // always-on domain: only the power-up reset and software writes touch it, never standby exit
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aon_q <= `LPDH_AON_RESET;
    end else if (aon_wr_i) begin
      aon_q <= aon_wdata_i;
    end
  end

  assign slow_osc_run_o = !(standby && st_q == ST_LOWP) ||
                          aon_q[`LPDH_AON_BIT_OSC];

  assign system_clock_en_o = (st_q != ST_LOWP) && (st_q != ST_WAKE);
  assign mode_busy_o       = (st_q != ST_RUN);
  // both flash arrays leave low power while the wake sequence counts
  assign code_flash_wake_o = (st_q == ST_WAKE);
  assign data_flash_wake_o = (st_q == ST_WAKE);
  assign debug_pwr_on_o    = !gated;

  assign tdo_o    = hold_q ? hold_val_q : jtag_tdo_i;
  assign tdo_oe_o = hold_q | (jtag_tdo_oe_i & !gated);

  lpdh_clkdiv u_clkdiv (
    .clk_i                (clk_i),
    .rst_b_i              (rst_b_i),
    .en_i                 (cfg_q[`LPDH_BIT_CKOE]),
    .div_i                (cfg_q[`LPDH_DIV_HI:`LPDH_DIV_LO]),
    .run_i                (system_clock_en_o),
    .debug_clock_output_o (debug_clock_output_o)
  );
endmodule // lpdh_top

/* File: sim/lpdh_checker.sv */
// port assertions for the low-power debug handshake
// assumes binding to lpdh_top with the testbench holding jtag inputs low
`timescale 1ns/1ps
module lpdh_checker (
  input wire        clk_i,
  input wire        rst_b_i,
  input wire        mode_wr_i,
  input wire [3:0]  mode_target_i,
  input wire        wake_timer_i,
  input wire        wake_pin_i,
  input wire [31:0] dbg_rdata_o,
  input wire        tdo_o,
  input wire        tdo_oe_o,
  input wire        system_clock_en_o,
  input wire        mode_busy_o,
  input wire        sw_resume_o,
  input wire        code_flash_wake_o,
  input wire        data_flash_wake_o,
  input wire        slow_osc_run_o,
  input wire [15:0] aon_q,
  input wire [3:0]  mode_q
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  a_flag_raise: assert property (mode_wr_i && !mode_busy_o && dbg_rdata_o[0] &&
    mode_target_i inside {4'h8, 4'ha} |=> dbg_rdata_o[8] && mode_busy_o) else $error("no flag");
  a_entry_held: assert property (mode_busy_o && system_clock_en_o && dbg_rdata_o[8]
    |=> system_clock_en_o) else $error("entry not held");
  a_pin_high: assert property ($fell(system_clock_en_o) && dbg_rdata_o[0] && mode_q != 4'hd
    |-> tdo_oe_o && tdo_o) else $error("pin not high");
  a_wake_low: assert property (!system_clock_en_o && tdo_oe_o && tdo_o &&
    (wake_timer_i || wake_pin_i) |=> tdo_oe_o && !tdo_o && code_flash_wake_o) else $error("no wake");
  a_flash_pair: assert property ($rose(code_flash_wake_o) |->
    (code_flash_wake_o && data_flash_wake_o) [*8]) else $error("flash exits apart");
  a_wait_forever: assert property (mode_busy_o && dbg_rdata_o[8]
    |=> mode_busy_o || sw_resume_o) else $error("wait left");
  a_resume_clean: assert property (sw_resume_o |-> !dbg_rdata_o[8] && !mode_busy_o
    ##1 !sw_resume_o) else $error("bad resume");
  a_osc_kept: assert property (aon_q[0] |-> slow_osc_run_o) else $error("osc off");
endmodule // lpdh_checker

/* File: sim/lpdh_dbg_model.sv */
// debugger probe: answers entry and exit handshakes over the config port
// assumes its write is ored with the bench's own config writes
`timescale 1ns/1ps
module lpdh_dbg_model #(parameter int DLY = 4) (
  input  wire         clk_i,
  input  wire  [31:0] cfg_i,
  input  wire         busy_i,
  input  wire         tdo_i,
  input  wire         tdo_oe_i,
  input  wire         clkrun_i,
  output logic        wr_o,
  output logic [31:0] wdata_o
);
  initial begin
    wr_o = 1'b0;
    wdata_o = 32'h0;
    forever begin
      @(negedge clk_i);
      if (busy_i && cfg_i[8] && clkrun_i) begin
        repeat (DLY) @(negedge clk_i);
        wdata_o = cfg_i & 32'hffff_feff;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        repeat (3) @(negedge clk_i);
      end else if (busy_i && tdo_oe_i && !tdo_i && !clkrun_i) begin
        repeat (DLY) @(negedge clk_i);
        wdata_o = cfg_i | 32'h100;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        wait (!busy_i);
      end
    end
  end
endmodule // lpdh_dbg_model

/* File: sim/testbench.sv */
// testbench for lpdh_top with a debugger probe model
// assumes jtag data and enable are idle low throughout
`timescale 1ns/1ps
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        mode_wr_i = 1'b0;
  logic [3:0]  mode_target_i = 4'h0;
  logic        aon_wr_i = 1'b0;
  logic        tb_wr = 1'b0;
  logic [31:0] tb_wdata = 32'h0;
  logic        wake_timer_i = 1'b0;
  logic        wake_pin_i = 1'b0;
  wire         m_wr;
  wire  [31:0] m_wdata;
  wire  [31:0] dbg_rdata_o;
  wire  [15:0] aon_q;
  wire  [3:0]  mode_q;
  wire         tdo_o, tdo_oe_o, system_clock_en_o, mode_busy_o, sw_resume_o, code_flash_wake_o;
  wire         data_flash_wake_o, slow_osc_run_o, debug_pwr_on_o, debug_clock_output_o;
  int          bad_count = 0, checks_done = 0, cyc = 0, edges = 0;
  always #12.5 clk_i = ~clk_i;
  always @(posedge debug_clock_output_o) edges++;
  lpdh_top i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .mode_wr_i(mode_wr_i),
    .mode_target_i(mode_target_i), .aon_wr_i(aon_wr_i), .aon_wdata_i(16'h0000),
    .dbg_wr_i(tb_wr | m_wr), .dbg_wdata_i(tb_wr ? tb_wdata : m_wdata), .dbg_rdata_o(dbg_rdata_o),
    .wake_timer_i(wake_timer_i), .wake_pin_i(wake_pin_i), .jtag_tdo_i(1'b0), .jtag_tdo_oe_i(1'b0),
    .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .system_clock_en_o(system_clock_en_o),
    .mode_busy_o(mode_busy_o), .sw_resume_o(sw_resume_o), .code_flash_wake_o(code_flash_wake_o),
    .data_flash_wake_o(data_flash_wake_o), .slow_osc_run_o(slow_osc_run_o),
    .debug_pwr_on_o(debug_pwr_on_o), .aon_q(aon_q), .mode_q(mode_q),
    .debug_clock_output_o(debug_clock_output_o));
  lpdh_dbg_model #(.DLY(4)) i_dbg (.clk_i(clk_i), .cfg_i(dbg_rdata_o), .busy_i(mode_busy_o),
    .tdo_i(tdo_o), .tdo_oe_i(tdo_oe_o), .clkrun_i(system_clock_en_o), .wr_o(m_wr),
    .wdata_o(m_wdata));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cfg_wr(input logic [31:0] d);
    @(negedge clk_i);
    tb_wdata = d;
    tb_wr = 1'b1;
    @(negedge clk_i);
    tb_wr = 1'b0;
  endtask
  // h: handshake expected, o: expected {osc, debug power} while asleep
  task automatic lp_run(input logic [3:0] m, input logic w, input logic h, input logic [1:0] o);
    int n;
    @(negedge clk_i);
    mode_target_i = m;
    mode_wr_i = 1'b1;
    @(negedge clk_i);
    mode_wr_i = 1'b0;
    chk(dbg_rdata_o[8], h);
    for (n = 0; n < 50 && system_clock_en_o; n++) @(negedge clk_i);
    chk({tdo_oe_o, tdo_o, slow_osc_run_o, debug_pwr_on_o}, {h, h, o});
    wake_timer_i = !w;
    wake_pin_i = w;
    @(negedge clk_i);
    wake_timer_i = 1'b0;
    wake_pin_i = 1'b0;
    chk({tdo_oe_o, tdo_o}, {h, 1'b0});
    for (n = 0; n < 2000 && code_flash_wake_o === 1'b1; n++) @(negedge clk_i);
    chk(n, 1680);
    for (n = 0; n < 100 && sw_resume_o !== 1'b1; n++) @(negedge clk_i);
    chk({sw_resume_o, mode_busy_o, dbg_rdata_o[8], tdo_oe_o}, 4'b1000);
    $display("test mode %h done", m);
  endtask
  // ceiling well above the roughly 7000 cycles the tests need
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test;
    end
  end
  initial begin
    repeat (2) @(negedge clk_i);
    rst_b_i = 1'b1;
    chk(dbg_rdata_o, 32'h0);
    chk(aon_q, 16'h0001);
    cfg_wr(32'hffff_ffff);
    chk(dbg_rdata_o, 32'h10f);
    for (int d = 0; d < 5; d++) begin
      cfg_wr(d == 4 ? 32'h0 : 32'h2 | (d << 2));
      edges = 0;
      repeat (32) @(negedge clk_i);
      chk(edges, d == 4 ? 0 : 32 >> d);
    end
    $display("test config done");
    cfg_wr(32'h1);
    lp_run(4'h8, 1'b0, 1'b1, 2'b11);
    lp_run(4'ha, 1'b1, 1'b1, 2'b11);
    cfg_wr(32'h0);
    lp_run(4'ha, 1'b0, 1'b0, 2'b11);
    @(negedge clk_i);
    aon_wr_i = 1'b1;
    @(negedge clk_i);
    aon_wr_i = 1'b0;
    cfg_wr(32'h2);
    lp_run(4'hd, 1'b1, 1'b0, 2'b00);
    chk(aon_q, 16'h0000);
    chk(dbg_rdata_o, 32'h0);
    end_of_test;
  end
endmodule // testbench
bind lpdh_top lpdh_checker i_chk (.*);
